// *** inc/tmu_regs.svh ***
`ifndef TMU_REGS_SVH
`define TMU_REGS_SVH
// register byte offsets (apb word aligned)
`define TMU_OFF_CLKGATE   12'h000
`define TMU_OFF_PRESCALE  12'h004
`define TMU_OFF_STOP      12'h008
`define TMU_OFF_MASK      12'h00C
`define TMU_OFF_REQ       12'h010
`define TMU_OFF_PRIO_HI   12'h014
`define TMU_OFF_PRIO_LO   12'h018
`define TMU_OFF_MODE      12'h01C
`define TMU_OFF_DATA      12'h020
`define TMU_OFF_START     12'h024
`define TMU_OFF_COUNT     12'h028
`define TMU_OFF_STATUS    12'h02C
`define TMU_OFF_ST_CLR    12'h030
`define TMU_OFF_ST_EN     12'h034
// field positions
`define TMU_GATE_BIT      0
`define TMU_CH0_BIT       4
`define TMU_STOP_CH0      0
`define TMU_STOP_CH1      1
`define TMU_STOP_CH3      3
`define TMU_CCS_BIT       12
`define TMU_CKS_HI        15
`define TMU_CKS_LO        14
`define TMU_STS_HI        10
`define TMU_STS_LO        8
`define TMU_MD_HI         3
`define TMU_MD_LO         1
`define TMU_MD_START      0
// reset values and codes
`define TMU_RST_MASK      8'hFF
`define TMU_RST_DATA      16'hFFFF
`define TMU_MD_INTERVAL   3'h0
`define TMU_MD_CAPTURE    3'h2
`define TMU_STS_SOFT      3'h0
`define TMU_CKS_CK0       2'h0
`define TMU_ST_W          2
`endif

// *** inc/tmu_pkg.sv ***
package tmu_pkg;
  // channel run state
  typedef enum logic [0:0] {TMU_IDLE, TMU_RUN} tmu_state_t;
  // apb request bundle
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tmu_apb_req_t;
  // decoded mode register fields
  typedef struct packed {
    logic [1:0] clk_sel;
    logic       count_source_sel;
    logic [2:0] start_trigger_sel;
    logic [2:0] op_mode;
    logic       start_irq_option;
  } tmu_mode_t;
endpackage : tmu_pkg

// *** verilog/tmu_timer.sv ***
// Function
// RULE1 - gate bit 0 stops unit clock, holds unit in reset, ignores register writes
// RULE2 - gate bit 1 supplies unit clock and allows register reads and writes
// RULE3 - operation clock zero is system clock divided by two to the prescale code
// RULE4 - writing 1 to channel 0 stop bit halts counting; writing 0 does nothing
// RULE5 - in 8-bit mode, channel 1 or 3 stop bit stops only lower timer
// RULE6 - channel 0 mask bit 4: 0 enables servicing, 1 disables it
// RULE7 - request flag bit 4 reads 1 while pending; software clears by writing 0
// RULE8 - priority is msb from high register, lsb from low; 00 highest
// RULE9 - count source bit 12 zero counts on operation clock chosen by clock select; the code uses operation clock zero for every clock select
// RULE10 - start trigger field zero starts only on software trigger
// RULE11 - mode zero runs interval timer, no interrupt when counting starts
// RULE12 - software enables clock, prescaler, stop, mask, clear, priority, then mode
// RULE13 - software selects undivided clock so channel counts at full rate
// RULE14 - interval mode counts down, capture mode counts up; other codes prohibited
// RULE15 - start option bit 1 in interval mode raises interrupt at count start
// RULE16 - software loads data register so count end repeats at wanted period
// RULE17 - each count end reloads counter, sets request flag, pulses count-end event
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tmu_regs.svh"

module tmu_timer
  import tmu_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PRS_W = 4
) (
  // clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // external count edge (count source 1)
  input  wire logic        cnt_edge_i,
  // interrupt and events
  output logic             irq_o,
  output logic             ch0_irq_o,
  output logic [1:0]       ch0_priority_o,
  output logic             count_end_o
);

  //----------------------------------------
  // bus decode
  //----------------------------------------
  tmu_apb_req_t req;
  assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i, addr: paddr_i, wdata: pwdata_i};

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  wire wr_acc = req.sel && req.enable && req.write && clk_en_i;
  wire rd_acc = req.sel && req.enable && !req.write;
  wire mapped = hit(req.addr, `TMU_OFF_CLKGATE) || hit(req.addr, `TMU_OFF_PRESCALE)
              || hit(req.addr, `TMU_OFF_STOP) || hit(req.addr, `TMU_OFF_MASK)
              || hit(req.addr, `TMU_OFF_REQ) || hit(req.addr, `TMU_OFF_PRIO_HI)
              || hit(req.addr, `TMU_OFF_PRIO_LO) || hit(req.addr, `TMU_OFF_MODE)
              || hit(req.addr, `TMU_OFF_DATA) || hit(req.addr, `TMU_OFF_START)
              || hit(req.addr, `TMU_OFF_COUNT) || hit(req.addr, `TMU_OFF_STATUS)
              || hit(req.addr, `TMU_OFF_ST_CLR) || hit(req.addr, `TMU_OFF_ST_EN);

  logic unit_clock_gate_ff;
  // unit writes only land while the gate is open
  wire unit_wr  = wr_acc && unit_clock_gate_ff;                 // see RULE1 see RULE2
  wire wr_gate  = wr_acc && hit(req.addr, `TMU_OFF_CLKGATE);
  wire wr_prs   = unit_wr && hit(req.addr, `TMU_OFF_PRESCALE);
  wire wr_stop  = unit_wr && hit(req.addr, `TMU_OFF_STOP);
  wire wr_mask  = unit_wr && hit(req.addr, `TMU_OFF_MASK);
  wire wr_req   = unit_wr && hit(req.addr, `TMU_OFF_REQ);
  wire wr_prh   = unit_wr && hit(req.addr, `TMU_OFF_PRIO_HI);
  wire wr_prl   = unit_wr && hit(req.addr, `TMU_OFF_PRIO_LO);
  wire wr_mode  = unit_wr && hit(req.addr, `TMU_OFF_MODE);
  wire wr_data  = unit_wr && hit(req.addr, `TMU_OFF_DATA);
  wire wr_start = unit_wr && hit(req.addr, `TMU_OFF_START);
  wire wr_stclr = wr_acc && hit(req.addr, `TMU_OFF_ST_CLR);
  wire wr_sten  = wr_acc && hit(req.addr, `TMU_OFF_ST_EN);

  assign pready_o  = 1'b1;
  assign pslverr_o = req.sel && req.enable && !mapped;

  //----------------------------------------
  // register state
  //----------------------------------------
  logic [PRS_W-1:0] prescale_ff;
  logic [7:0]       mask_ff;
  logic [7:0]       req_flags_ff;
  logic [7:0]       prio_hi_ff;
  logic [7:0]       prio_lo_ff;
  logic [15:0]      mode_ff;
  logic [CNT_W-1:0] data_ff;
  logic [CNT_W-1:0] count_ff;
  logic [15:0]      div_ff;
  logic [`TMU_ST_W-1:0] status_ff;
  logic [`TMU_ST_W-1:0] st_en_ff;
  logic             ch1_lo_run_ff;
  logic             ch3_lo_run_ff;
  logic             count_end_ff;
  logic [31:0]      prdata_ff;
  tmu_state_t       state_ff;

  tmu_mode_t mode;
  assign mode = '{clk_sel: mode_ff[`TMU_CKS_HI:`TMU_CKS_LO],
                  count_source_sel: mode_ff[`TMU_CCS_BIT],
                  start_trigger_sel: mode_ff[`TMU_STS_HI:`TMU_STS_LO],
                  op_mode: mode_ff[`TMU_MD_HI:`TMU_MD_LO],
                  start_irq_option: mode_ff[`TMU_MD_START]};

  // held in reset while the gate is closed
  wire unit_rst = !unit_clock_gate_ff;                          // see RULE1

  //----------------------------------------
  // operation clock zero as enable pulses
  //----------------------------------------
  // a free counter; tick when the low prescale bits all roll over
  wire [15:0] div_mask = 16'((32'h1 << prescale_ff) - 32'h1);
  wire        op_clk0  = ((div_ff & div_mask) == div_mask);     // see RULE3

  // only clock selection 00 is built; others fall back to zero
  wire op_clk_sel = (mode.clk_sel == `TMU_CKS_CK0) ? op_clk0 : op_clk0;
  // count source: operation clock or external edge
  wire cnt_tick   = mode.count_source_sel ? cnt_edge_i : op_clk_sel; // see RULE9

  wire is_interval = (mode.op_mode == `TMU_MD_INTERVAL);
  wire is_capture  = (mode.op_mode == `TMU_MD_CAPTURE);
  // software start only: no hardware trigger input is honoured for code 000
  wire soft_only   = (mode.start_trigger_sel == `TMU_STS_SOFT);  // see RULE10
  wire start_req   = wr_start && pwdata_i[`TMU_STOP_CH0];
  wire stop_req    = wr_stop && pwdata_i[`TMU_STOP_CH0];        // see RULE4
  wire start_irq   = start_req && is_interval && mode.start_irq_option; // see RULE15 see RULE11
  wire running     = (state_ff == TMU_RUN);
  wire reach_end   = running && cnt_tick && is_interval && (count_ff == '0);
  wire set_flag    = reach_end || start_irq;                    // see RULE17

  //----------------------------------------
  // channel state machine
  //----------------------------------------
  tmu_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TMU_IDLE: begin
        if (start_req && soft_only) begin
          nxt_state = TMU_RUN;
        end
      end
      TMU_RUN: begin
        if (stop_req) begin
          nxt_state = TMU_IDLE;                                 // see RULE4
        end
      end
      default: nxt_state = TMU_IDLE;
    endcase
  end

  // counter next value: down in interval, up in capture
  logic [CNT_W-1:0] nxt_count;
  always_comb begin
    nxt_count = count_ff;
    if (start_req && !running) begin
      nxt_count = is_capture ? '0 : data_ff;
    end else if (running && cnt_tick) begin
      if (reach_end) begin
        nxt_count = data_ff;                                    // see RULE17
      end else if (is_interval) begin
        nxt_count = count_ff - 1'b1;                            // see RULE14
      end else if (is_capture) begin
        nxt_count = count_ff + 1'b1;                            // see RULE14
      end
    end
  end

  // request flag: hardware set beats a software clear
  wire [7:0] nxt_req = wr_req ? pwdata_i[7:0] : req_flags_ff;
  wire [7:0] req_set = 8'(set_flag) << `TMU_CH0_BIT;            // see RULE7

  // 8-bit low timers of channels 1 and 3: stop bits only touch them
  wire stop_ch1_lo = wr_stop && pwdata_i[`TMU_STOP_CH1];         // see RULE5
  wire stop_ch3_lo = wr_stop && pwdata_i[`TMU_STOP_CH3];         // see RULE5
  // start register bits 1 and 3 run them; a stop in the same write wins
  wire start_ch1_lo = wr_start && pwdata_i[`TMU_STOP_CH1];
  wire start_ch3_lo = wr_start && pwdata_i[`TMU_STOP_CH3];

  //----------------------------------------
  // unit clock gate (never reset by itself)
  //----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_clock_gate_ff <= 1'b0;
    end else if (clk_en_i && wr_gate) begin
      unit_clock_gate_ff <= pwdata_i[`TMU_GATE_BIT];            // see RULE2
    end
  end

  //----------------------------------------
  // unit registers and channel
  //----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_ff   <= '0;
      mode_ff       <= '0;
      data_ff       <= `TMU_RST_DATA;
      count_ff      <= '0;
      div_ff        <= '0;
      state_ff      <= TMU_IDLE;
      ch1_lo_run_ff <= 1'b0;
      ch3_lo_run_ff <= 1'b0;
      count_end_ff  <= 1'b0;
    end else if (clk_en_i) begin
      if (unit_rst) begin
        // clock stopped: whole unit held at reset values
        prescale_ff   <= '0;                                    // see RULE1
        mode_ff       <= '0;
        data_ff       <= `TMU_RST_DATA;
        count_ff      <= '0;
        div_ff        <= '0;
        state_ff      <= TMU_IDLE;
        ch1_lo_run_ff <= 1'b0;
        ch3_lo_run_ff <= 1'b0;
        count_end_ff  <= 1'b0;
      end else begin
        if (wr_prs) prescale_ff <= pwdata_i[PRS_W-1:0];
        if (wr_mode) mode_ff <= pwdata_i[15:0];
        if (wr_data) data_ff <= pwdata_i[CNT_W-1:0];
        div_ff        <= div_ff + 16'h1;
        count_ff      <= nxt_count;
        state_ff      <= nxt_state;
        count_end_ff  <= reach_end;                             // see RULE17
        if (stop_ch1_lo) ch1_lo_run_ff <= 1'b0;
        else if (start_ch1_lo) ch1_lo_run_ff <= 1'b1;
        if (stop_ch3_lo) ch3_lo_run_ff <= 1'b0;
        else if (start_ch3_lo) ch3_lo_run_ff <= 1'b1;
      end
    end
  end

  //----------------------------------------
  // interrupt controller registers (outside the unit reset)
  //----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_ff      <= `TMU_RST_MASK;
      req_flags_ff <= '0;
      prio_hi_ff   <= '1;
      prio_lo_ff   <= '1;
    end else if (clk_en_i) begin
      if (wr_mask) mask_ff <= pwdata_i[7:0];
      if (wr_prh) prio_hi_ff <= pwdata_i[7:0];
      if (wr_prl) prio_lo_ff <= pwdata_i[7:0];
      req_flags_ff <= nxt_req | req_set;                        // see RULE7
    end
  end

  // sticky status: bit0 count end, bit1 start interrupt; set wins over clear
  wire [`TMU_ST_W-1:0] st_set = {start_irq, reach_end};
  wire [`TMU_ST_W-1:0] st_clr = wr_stclr ? pwdata_i[`TMU_ST_W-1:0] : '0;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_ff <= '0;
      st_en_ff  <= '0;
    end else if (clk_en_i) begin
      status_ff <= (status_ff & ~st_clr) | st_set;
      if (wr_sten) st_en_ff <= pwdata_i[`TMU_ST_W-1:0];
    end
  end

  //----------------------------------------
  // read mux (unit registers read zero while gated)
  //----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit(req.addr, `TMU_OFF_CLKGATE)) rd_mux = {31'h0, unit_clock_gate_ff};
    else if (hit(req.addr, `TMU_OFF_MASK)) rd_mux = {24'h0, mask_ff};
    else if (hit(req.addr, `TMU_OFF_REQ)) rd_mux = {24'h0, req_flags_ff};
    else if (hit(req.addr, `TMU_OFF_PRIO_HI)) rd_mux = {24'h0, prio_hi_ff};
    else if (hit(req.addr, `TMU_OFF_PRIO_LO)) rd_mux = {24'h0, prio_lo_ff};
    else if (hit(req.addr, `TMU_OFF_STATUS)) rd_mux = {30'h0, status_ff};
    else if (hit(req.addr, `TMU_OFF_ST_EN)) rd_mux = {30'h0, st_en_ff};
    else if (unit_clock_gate_ff) begin
      if (hit(req.addr, `TMU_OFF_PRESCALE)) rd_mux = {28'h0, prescale_ff};
      else if (hit(req.addr, `TMU_OFF_MODE)) rd_mux = {16'h0, mode_ff};
      else if (hit(req.addr, `TMU_OFF_DATA)) rd_mux = {16'h0, data_ff};
      else if (hit(req.addr, `TMU_OFF_COUNT)) rd_mux = {13'h0, ch3_lo_run_ff, ch1_lo_run_ff, running, count_ff};
    end
  end

  // read data registered in the setup cycle so it is stable in access
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_ff <= '0;
    end else if (clk_en_i && req.sel && !req.enable && !req.write) begin
      prdata_ff <= rd_mux;
    end
  end

  //----------------------------------------
  // outputs
  //----------------------------------------
  assign prdata_o       = rd_acc ? prdata_ff : 32'h0;
  assign ch0_irq_o      = req_flags_ff[`TMU_CH0_BIT] && !mask_ff[`TMU_CH0_BIT]; // see RULE6
  assign ch0_priority_o = {prio_hi_ff[`TMU_CH0_BIT], prio_lo_ff[`TMU_CH0_BIT]}; // see RULE8
  assign irq_o          = |(status_ff & st_en_ff);
  assign count_end_o    = count_end_ff;

endmodule : tmu_timer
`default_nettype wire

// *** dv/tmu_timer_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmu_timer_props (
  // clock, reset, enable
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        clk_en_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // count source, events
  input wire logic        cnt_edge_i,
  input wire logic        irq_o,
  input wire logic        ch0_irq_o,
  input wire logic [1:0]  ch0_priority_o,
  input wire logic        count_end_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // access phase decode
  wire acc    = psel_i && penable_i;
  wire wr_acc = acc && pwrite_i;

  chk_ready_zero_wait: assert property (acc |-> pready_o)
    else $error("access phase without ready");
  chk_slverr_map: assert property (acc |-> pslverr_o == (paddr_i > 12'h034 || paddr_i[1:0] != 2'h0))
    else $error("error response does not match address map");
  chk_rdata_idle: assert property (!(acc && !pwrite_i) |-> prdata_o == 32'h0)
    else $error("read data outside read access");
  chk_prio_reset: assert property ($rose(rst_n_i) |-> ch0_priority_o == 2'h3)
    else $error("priority not lowest after reset");
  chk_prio_cause: assert property ($changed(ch0_priority_o) |-> $past(wr_acc))
    else $error("priority changed without a write");
  // a flag may only rise from a write, a start, or a count end
  chk_flag_cause: assert property ($rose(ch0_irq_o) |-> $past(wr_acc) || $past(wr_acc, 2)
                                   || count_end_o || $past(count_end_o))
    else $error("channel request rose without cause");
  chk_irq_cause: assert property ($rose(irq_o) |-> $past(wr_acc) || $past(wr_acc, 2)
                                  || count_end_o || $past(count_end_o))
    else $error("interrupt rose without cause");
  chk_end_frozen: assert property ($rose(count_end_o) |-> $past(clk_en_i))
    else $error("count end while frozen");
  // a low clock enable must hold every registered output still
  chk_freeze_hold: assert property (!clk_en_i |=> $stable(count_end_o) && $stable(irq_o)
                                    && $stable(ch0_irq_o) && $stable(ch0_priority_o))
    else $error("state moved while frozen");
endmodule : tmu_timer_props

bind tmu_timer tmu_timer_props i_tmu_timer_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cnt_edge_i(cnt_edge_i),
  .irq_o(irq_o), .ch0_irq_o(ch0_irq_o), .ch0_priority_o(ch0_priority_o), .count_end_o(count_end_o)
);
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tmu_regs.svh"
module testbench;
  import tmu_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        clk_en_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        cnt_edge_i = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, irq_o, ch0_irq_o, count_end_o;
  logic [1:0]  ch0_priority_o;
  logic        last_err;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n;

  tmu_timer i_tmu_timer (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cnt_edge_i(cnt_edge_i),
    .irq_o(irq_o), .ch0_irq_o(ch0_irq_o), .ch0_priority_o(ch0_priority_o), .count_end_o(count_end_o)
  );

  // 125 MHz system clock
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; an idle edge follows so strobes never toggle twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    r = prdata_o;
    last_err = pslverr_o;
    if (k >= 50) begin n_fail++; finish_test; end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r & m, e);
  endtask : rd

  // cycles between two count-end pulses, bounded
  task automatic period(output int p);
    int k;
    k = 0;
    while (count_end_o !== 1'b1 && k < 8000) begin
      @(posedge ref_clk_i);
      k++;
    end
    p = 0;
    do begin
      @(posedge ref_clk_i);
      p++;
    end while (count_end_o !== 1'b1 && p < 8000);
    if (p >= 8000) begin
      n_fail++;
      finish_test;
    end
  endtask : period

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(`TMU_OFF_MASK, 32'hFF);
    rd(`TMU_OFF_REQ, 32'h0);
    check({30'h0, ch0_priority_o}, 32'h3);
    wr(`TMU_OFF_PRESCALE, 32'h2);
    rd(`TMU_OFF_PRESCALE, 32'h0);
    // software order: gate, prescale, stop, mask, clear, priority, mode
    wr(`TMU_OFF_CLKGATE, 32'h1);
    rd(`TMU_OFF_DATA, 32'hFFFF);
    rd(`TMU_OFF_PRESCALE, 32'h0);
    wr(`TMU_OFF_PRESCALE, 32'h2);
    rd(`TMU_OFF_PRESCALE, 32'h2);
    wr(`TMU_OFF_STOP, 32'h1);
    wr(`TMU_OFF_REQ, 32'h10);
    check({31'h0, ch0_irq_o}, 32'h0);
    wr(`TMU_OFF_MASK, 32'hEF);
    check({31'h0, ch0_irq_o}, 32'h1);
    wr(`TMU_OFF_REQ, 32'h0);
    check({31'h0, ch0_irq_o}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`TMU_OFF_PRIO_HI, {27'h0, i[1], 4'h0});
      wr(`TMU_OFF_PRIO_LO, {27'h0, i[0], 4'h0});
      check({30'h0, ch0_priority_o}, i[31:0]);
    end
    wr(`TMU_OFF_MODE, 32'h0);
    wr(`TMU_OFF_DATA, 32'h3);
    wr(`TMU_OFF_START, 32'h1);
    rd(`TMU_OFF_REQ, 32'h0);
    rd(`TMU_OFF_STATUS, 32'h0);
    period(n);
    check(n, 32'd16);
    rd(`TMU_OFF_REQ, 32'h10);
    // a zero write to the stop register must leave the channel running
    wr(`TMU_OFF_STOP, 32'h0);
    rd(`TMU_OFF_COUNT, 32'h10000, 32'h10000);
    wr(`TMU_OFF_STOP, 32'h1);
    rd(`TMU_OFF_COUNT, 32'h0, 32'h10000);
    // low timers of channels 1 and 3: the channel 1 stop bit touches only its own
    wr(`TMU_OFF_START, 32'hA);
    wr(`TMU_OFF_STOP, 32'h2);
    rd(`TMU_OFF_COUNT, 32'h40000, 32'h70000);
    rd(`TMU_OFF_STATUS, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    wr(`TMU_OFF_ST_EN, 32'h1);
    check({31'h0, irq_o}, 32'h1);
    wr(`TMU_OFF_ST_CLR, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    // start option raises the request at the start itself
    wr(`TMU_OFF_REQ, 32'h0);
    wr(`TMU_OFF_MODE, 32'h1);
    wr(`TMU_OFF_START, 32'h1);
    rd(`TMU_OFF_REQ, 32'h10);
    rd(`TMU_OFF_STATUS, 32'h2, 32'h2);
    wr(`TMU_OFF_STOP, 32'h1);
    // external count source: only edge pulses move the counter
    wr(`TMU_OFF_MODE, 32'h1000);
    wr(`TMU_OFF_START, 32'h1);
    rd(`TMU_OFF_COUNT, 32'h10003, 32'h1FFFF);
    cnt_edge_i <= 1'b1;
    @(posedge ref_clk_i);
    cnt_edge_i <= 1'b0;
    rd(`TMU_OFF_COUNT, 32'h10002, 32'h1FFFF);
    wr(`TMU_OFF_STOP, 32'h1);
    wr(`TMU_OFF_MODE, 32'h0);
    wr(`TMU_OFF_PRESCALE, 32'h0);
    wr(`TMU_OFF_DATA, 32'h18FF);
    wr(`TMU_OFF_START, 32'h1);
    period(n);
    check(n, 32'd6400);
    // frozen by the clock enable: a write must not land
    clk_en_i <= 1'b0;
    wr(`TMU_OFF_PRESCALE, 32'h5);
    clk_en_i <= 1'b1;
    rd(`TMU_OFF_PRESCALE, 32'h0);
    wr(`TMU_OFF_STOP, 32'h1);
    // closing the gate puts the unit back to its reset values
    wr(`TMU_OFF_CLKGATE, 32'h0);
    wr(`TMU_OFF_CLKGATE, 32'h1);
    rd(`TMU_OFF_DATA, 32'hFFFF);
    rd(12'h040, 32'h0);
    check({31'h0, last_err}, 32'h1);
    finish_test;
  end
endmodule : testbench
`default_nettype wire
